// [rtl/tick_timer_pkg.sv]
// shared constants for the down-count tick timer
package tick_timer_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [11:0] OFF_CONTROL_STATUS = 12'h010;
	localparam logic [11:0] OFF_RELOAD_VALUE = 12'h014;
	localparam logic [11:0] OFF_PRESENT_COUNT = 12'h018;
	localparam logic [11:0] OFF_CALIBRATION = 12'h01C;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	// ----------------------------------------
	// fields
	// ----------------------------------------
	localparam int COUNT_W = 24;
	localparam int BIT_ENABLE = 0;
	localparam int BIT_ZERO_IRQ_ENABLE = 1;
	localparam int BIT_COUNT_CLOCK_SELECT = 2;
	localparam int BIT_REACHED_ZERO = 16;
	localparam int BIT_CALIB_INEXACT = 30;
	localparam int BIT_NO_REF_CLOCK = 31;
	// ----------------------------------------
	// reset values and rates
	// ----------------------------------------
	localparam logic [COUNT_W-1:0] COUNT_RESET = 24'h000000;
	localparam logic [COUNT_W-1:0] RELOAD_RESET = 24'h000000;
	localparam logic [DATA_W-1:0] CALIB_RESET = 32'h00000004;
	localparam logic [2:0] CONTROL_RESET = 3'h0;
	localparam int REF_CLOCK_DIV = 2;
endpackage

// [rtl/half_rate_enable.sv]
// divider making the one-cycle reference-clock enable
`timescale 1ns/100ps
`default_nettype none
module half_rate_enable (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// enable pulse, one cycle in every REF_CLOCK_DIV
	output logic ref_tick
);
	logic [1:0] div_q;

	// free-running divider; the pulse comes straight from a flop
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			div_q <= 2'h0;
			ref_tick <= 1'b0;
		end else begin
			if (div_q == 2'(tick_timer_pkg::REF_CLOCK_DIV - 1)) begin
				div_q <= 2'h0;
			end else begin
				div_q <= div_q + 2'h1;
			end
			ref_tick <= (div_q == 2'(tick_timer_pkg::REF_CLOCK_DIV - 1));
		end
	end
endmodule // half_rate_enable
`default_nettype wire

// [rtl/down_count_tick_timer.sv]
// 24-bit down-counting tick timer with its four core registers
`timescale 1ns/100ps
`default_nettype none
module down_count_tick_timer (
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// private peripheral register port
	input wire logic reg_sel,
	input wire logic reg_write,
	input wire logic [tick_timer_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [tick_timer_pkg::DATA_W-1:0] reg_wdata,
	output logic [tick_timer_pkg::DATA_W-1:0] reg_rdata,
	output logic reg_rvalid,
	// calibration word from the system configuration block
	input wire logic [tick_timer_pkg::DATA_W-1:0] calib_source_config,
	// tick interrupt request, one-cycle pulse
	output logic tick_irq
);
	localparam int CW = tick_timer_pkg::COUNT_W;

	logic enable_q;
	logic zero_irq_enable_q;
	logic count_clock_select_q;
	logic reached_zero_flag_q;
	logic [CW-1:0] reload_q;
	logic [CW-1:0] count_q;
	logic [tick_timer_pkg::DATA_W-1:0] calib_q;
	logic ref_tick;
	logic count_tick;
	logic zero_evt;
	logic wr_csr, wr_rvr, wr_cvr, rd_csr, rd_any;

	// ----------------------------------------
	// clock selection
	// ----------------------------------------
	half_rate_enable u_half_rate (
		.clk(clk),
		.reset_n(reset_n),
		.ref_tick(ref_tick)
	);

	// full clock counts every cycle, reference clock every second one
	assign count_tick = count_clock_select_q | ref_tick;

	// ----------------------------------------
	// register decode
	// ----------------------------------------
	assign wr_csr = reg_sel & reg_write & (reg_addr == tick_timer_pkg::OFF_CONTROL_STATUS);
	assign wr_rvr = reg_sel & reg_write & (reg_addr == tick_timer_pkg::OFF_RELOAD_VALUE);
	assign wr_cvr = reg_sel & reg_write & (reg_addr == tick_timer_pkg::OFF_PRESENT_COUNT);
	assign rd_any = reg_sel & ~reg_write;
	assign rd_csr = rd_any & (reg_addr == tick_timer_pkg::OFF_CONTROL_STATUS);

	// zero event: a live decrement from one down to zero
	assign zero_evt = enable_q & count_tick & (count_q == 24'h000001) & ~wr_cvr;

	// ----------------------------------------
	// control bits
	// ----------------------------------------
	// writes to calibration are ignored, it only mirrors the config block
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			{count_clock_select_q, zero_irq_enable_q, enable_q} <= tick_timer_pkg::CONTROL_RESET;
		end else if (wr_csr) begin
			enable_q <= reg_wdata[tick_timer_pkg::BIT_ENABLE];
			zero_irq_enable_q <= reg_wdata[tick_timer_pkg::BIT_ZERO_IRQ_ENABLE];
			count_clock_select_q <= reg_wdata[tick_timer_pkg::BIT_COUNT_CLOCK_SELECT];
		end
	end

	// reload field, upper bits dropped
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reload_q <= tick_timer_pkg::RELOAD_RESET;
		end else if (wr_rvr) begin
			reload_q <= reg_wdata[CW-1:0];
		end
	end

	// ----------------------------------------
	// counter
	// ----------------------------------------
	// a write to the count wins over counting in the same cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			count_q <= tick_timer_pkg::COUNT_RESET;
		end else if (wr_cvr) begin
			count_q <= tick_timer_pkg::COUNT_RESET;
		end else if (enable_q && count_tick) begin
			if (count_q == tick_timer_pkg::COUNT_RESET) begin
				count_q <= reload_q;
			end else begin
				count_q <= count_q - 24'h000001;
			end
		end
	end

	// sticky flag; a zero event in the clearing cycle is kept
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reached_zero_flag_q <= 1'b0;
		end else if (zero_evt) begin
			reached_zero_flag_q <= 1'b1;
		end else if (rd_csr || wr_cvr) begin
			reached_zero_flag_q <= 1'b0;
		end
	end

	// interrupt pulse gated by its enable
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tick_irq <= 1'b0;
		end else begin
			tick_irq <= zero_evt & zero_irq_enable_q;
		end
	end

	// ----------------------------------------
	// calibration and read data
	// ----------------------------------------
	// config word is same-clock logic, so it is taken without a synchroniser
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			calib_q <= tick_timer_pkg::CALIB_RESET;
		end else begin
			calib_q <= {calib_source_config[tick_timer_pkg::BIT_NO_REF_CLOCK],
				calib_source_config[tick_timer_pkg::BIT_CALIB_INEXACT],
				6'h00, calib_source_config[CW-1:0]};
		end
	end

	// registered read answer; reserved bits and unmapped offsets read zero
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 32'h00000000;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= rd_any;
			if (rd_any) begin
				case (reg_addr)
					tick_timer_pkg::OFF_CONTROL_STATUS: begin
						reg_rdata <= {15'h0000, reached_zero_flag_q, 13'h0000,
							count_clock_select_q, zero_irq_enable_q, enable_q};
					end
					tick_timer_pkg::OFF_RELOAD_VALUE: begin
						reg_rdata <= {8'h00, reload_q};
					end
					tick_timer_pkg::OFF_PRESENT_COUNT: begin
						reg_rdata <= {8'h00, count_q};
					end
					tick_timer_pkg::OFF_CALIBRATION: begin
						reg_rdata <= calib_q;
					end
					default: begin
						reg_rdata <= 32'h00000000;
					end
				endcase
			end
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence live_step_s;
		enable_q && count_tick && !wr_cvr;
	endsequence

	sequence zero_evt_s;
		live_step_s ##0 (count_q == 24'h000001);
	endsequence

	count_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
		(!enable_q && !wr_cvr) |=> $stable(count_q) && !tick_irq)
		else $error("count moved while disabled");

	reload_load_a: assert property (@(posedge clk) disable iff (!reset_n)
		(live_step_s ##0 (count_q == 24'h000000)) |=> (count_q == $past(reload_q)))
		else $error("reload not taken at zero");

	count_down_a: assert property (@(posedge clk) disable iff (!reset_n)
		(live_step_s ##0 (count_q != 24'h000000)) |=> (count_q == $past(count_q) - 24'h000001))
		else $error("count did not step down by one");

	flag_set_a: assert property (@(posedge clk) disable iff (!reset_n)
		zero_evt_s |=> reached_zero_flag_q)
		else $error("reached-zero flag not set");

	flag_read_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
		(rd_csr && !zero_evt) ##1 (!zero_evt) |-> !reached_zero_flag_q [*2])
		else $error("flag survived a control read");

	count_write_a: assert property (@(posedge clk) disable iff (!reset_n)
		wr_cvr |=> (count_q == 24'h000000) && !reached_zero_flag_q)
		else $error("count write did not clear");

	irq_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
		zero_evt_s ##0 zero_irq_enable_q |=> tick_irq)
		else $error("enabled tick interrupt missing");

	irq_cause_a: assert property (@(posedge clk) disable iff (!reset_n)
		tick_irq |-> $past(zero_evt) && $past(zero_irq_enable_q))
		else $error("interrupt without cause");

	half_rate_a: assert property (@(posedge clk) disable iff (!reset_n)
		(!count_clock_select_q && ref_tick) |=> !ref_tick ##1 ref_tick)
		else $error("reference clock not half rate");

	count_read_a: assert property (@(posedge clk) disable iff (!reset_n)
		(rd_any && reg_addr == tick_timer_pkg::OFF_PRESENT_COUNT)
		|=> reg_rvalid && (reg_rdata == {8'h00, $past(count_q)}))
		else $error("present count read wrong");

	calib_read_a: assert property (@(posedge clk) disable iff (!reset_n)
		(rd_any && reg_addr == tick_timer_pkg::OFF_CALIBRATION)
		|=> (reg_rdata[29:24] == 6'h00) && (reg_rdata == $past(calib_q)))
		else $error("calibration read wrong");
endmodule // down_count_tick_timer
`default_nettype wire

// [sim/core_port_model.sv]
// bus-side model of the processor core driving the timer register port
`timescale 1ns/100ps
`default_nettype none
module core_port_model (
	// clock
	input wire logic clk,
	// register port
	output logic reg_sel,
	output logic reg_write,
	output logic [tick_timer_pkg::ADDR_W-1:0] reg_addr,
	output logic [tick_timer_pkg::DATA_W-1:0] reg_wdata,
	input wire logic [tick_timer_pkg::DATA_W-1:0] reg_rdata,
	input wire logic reg_rvalid
);
	// idle port at time zero
	initial begin
		reg_sel = 1'b0;
		reg_write = 1'b0;
		reg_addr = 12'h000;
		reg_wdata = 32'h00000000;
	end
	// one write; request left up so that calls run back to back
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(negedge clk);
		reg_sel = 1'b1;
		reg_write = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clk);
	endtask
	// release; stale address and data are inverted so nothing leans on them
	task automatic rel();
		@(negedge clk);
		reg_sel = 1'b0;
		reg_addr = ~reg_addr;
		reg_wdata = ~reg_wdata;
	endtask
	// read: valid stands only in the cycle after the taking edge, so it is caught there
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic ok);
		@(negedge clk);
		reg_sel = 1'b1;
		reg_write = 1'b0;
		reg_addr = a;
		@(posedge clk);
		#1;
		ok = reg_rvalid;
		d = reg_rdata;
		rel();
	endtask
endmodule // core_port_model
`default_nettype wire

// [sim/testbench.sv]
// self-checking bench for the down-count tick timer
`timescale 1ns/100ps
`default_nettype none
module testbench;
	localparam logic [11:0] CS = tick_timer_pkg::OFF_CONTROL_STATUS;
	localparam logic [11:0] RV = tick_timer_pkg::OFF_RELOAD_VALUE;
	localparam logic [11:0] PC = tick_timer_pkg::OFF_PRESENT_COUNT;
	localparam logic [11:0] CB = tick_timer_pkg::OFF_CALIBRATION;
	logic clk, reset_n, reg_sel, reg_write, reg_rvalid, tick_irq, ok;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, calib_source_config, v;
	int miscompares = 0, tests_run = 0, cyc = 0, n, i;
	down_count_tick_timer u_down_count_tick_timer (.clk(clk), .reset_n(reset_n),
		.reg_sel(reg_sel), .reg_write(reg_write), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.calib_source_config(calib_source_config), .tick_irq(tick_irq));
	core_port_model u_core_port_model (.clk(clk), .reg_sel(reg_sel), .reg_write(reg_write),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid));
	// ----------------------------------------
	// clock, timeout and helpers
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// ceiling well above the few hundred cycles the run needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			miscompares++;
			tally_and_finish();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask
	task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
		u_core_port_model.rd(a, v, ok);
		chk("read valid", {31'h0, ok}, 32'h1);
		chk(nm, v, exp);
	endtask
	// cycles up to the next tick pulse; 200 means none came
	task automatic gap(output int k);
		k = 0;
		do begin
			@(posedge clk);
			#1;
			k++;
		end while (tick_irq !== 1'b1 && k < 200);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		reset_n = 1'b0;
		calib_source_config = 32'hC0012345;
		repeat (12) @(negedge clk);
		reset_n = 1'b1;
		rdc("control", CS, 32'h0);
		rdc("reload", RV, 32'h0);
		rdc("count", PC, 32'h0);
		rdc("calibration", CB, 32'hC0012345);
		rdc("unmapped", 12'h020, 32'h0);
		// one enabled step from zero loads the full 24-bit reload
		u_core_port_model.wr(CB, 32'h0);
		u_core_port_model.wr(RV, 32'h00FFFFFF);
		u_core_port_model.wr(PC, 32'h0);
		u_core_port_model.wr(CS, 32'h5);
		u_core_port_model.wr(CS, 32'h0);
		u_core_port_model.rel();
		rdc("calibration", CB, 32'hC0012345);
		rdc("count", PC, 32'h00FFFFFF);
		rdc("count held", PC, 32'h00FFFFFF);
		rdc("reload", RV, 32'h00FFFFFF);
		rdc("control", CS, 32'h0);
		u_core_port_model.wr(PC, 32'h00000123);
		u_core_port_model.rel();
		rdc("count", PC, 32'h0);
		// software copies the calibration field into the reload register
		rdc("calibration", CB, 32'hC0012345);
		u_core_port_model.wr(RV, {8'h00, v[23:0]});
		u_core_port_model.rel();
		rdc("reload", RV, 32'h00012345);
		// full clock then half clock, reload 3
		for (i = 0; i < 2; i++) begin
			u_core_port_model.wr(RV, 32'h3);
			u_core_port_model.wr(PC, 32'h0);
			u_core_port_model.wr(CS, i ? 32'h3 : 32'h7);
			u_core_port_model.rel();
			gap(n);
			gap(n);
			chk("tick spacing", n, i ? 32'd8 : 32'd4);
			rdc("control", CS, i ? 32'h00010003 : 32'h00010007);
			u_core_port_model.wr(CS, 32'h0);
			u_core_port_model.wr(PC, 32'h00ABCDEF);
			u_core_port_model.rel();
			rdc("control", CS, 32'h0);
			rdc("count", PC, 32'h0);
		end
		// counting with the tick masked
		u_core_port_model.wr(CS, 32'h1);
		u_core_port_model.rel();
		gap(n);
		chk("masked tick", n, 32'd200);
		rdc("control", CS, 32'h00010001);
		// let a further zero event set the flag, then clear it by a count write
		repeat (10) @(posedge clk);
		u_core_port_model.wr(CS, 32'h0);
		u_core_port_model.wr(PC, 32'h0);
		u_core_port_model.rel();
		rdc("control", CS, 32'h0);
		rdc("count", PC, 32'h0);
		tally_and_finish();
	end
endmodule // testbench
`default_nettype wire
